//--- src/code_lock_pkg.sv
// Constants for the program code security lock
package code_lock_pkg;
    // ==================================================================
    // Register addresses
    localparam logic [7:0]  LOCK_CTRL_ADDR   = 8'hb2;   // Special register
    localparam logic [15:0] CONFIG_ONE_ADDR  = 16'h2005; // Configuration RAM
    // ==================================================================
    // Field positions
    localparam int BOOT_WINDOW_BIT  = 7;
    localparam int LOCK_BIT         = 6;
    localparam int FLASH_MEEN_BIT   = 1;
    localparam int FLASH_PWE_BIT    = 0;
    localparam int EMU_CLK_OFF_BIT  = 5;
    // ==================================================================
    // Reset values
    localparam logic [7:0]  LOCK_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  CONFIG_ONE_RESET = 8'h00;
    // ==================================================================
    // Timing
    localparam int BOOT_WINDOW_CYCLES = 32;
    localparam int BOOT_CNT_W         = 6;
    // Flash page holding boot code
    localparam logic [6:0]  BOOT_PAGE        = 7'h00;
    localparam int PAGE_W             = 7;
endpackage

//--- src/boot_window_timer.sv
// Boot window counter after reset release
`timescale 1ns/1ps
module boot_window_timer #(
    parameter int WINDOW = code_lock_pkg::BOOT_WINDOW_CYCLES
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Window state
    output logic      in_window_o
);
    logic [code_lock_pkg::BOOT_CNT_W-1:0] count;

    // ==================================================================
    // Counts processor cycles from reset release up to the window length
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (count != code_lock_pkg::BOOT_CNT_W'(WINDOW)) begin
            count <= count + 1'b1;
        end
    end

    // Window flag is registered so it is clean from the first cycle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            in_window_o <= 1'b1;
        end else begin
            in_window_o <= (count != code_lock_pkg::BOOT_CNT_W'(WINDOW - 1)) &&
                           (count != code_lock_pkg::BOOT_CNT_W'(WINDOW));
        end
    end
endmodule // boot_window_timer

//--- src/program_code_security_lock.sv
// Program code security lock: boot window, lock bit, flash and emulator gating
// Notes on behaviour
// - While locked, the emulator may only run global erase; its other operations are refused.
// - Lock can be set only by processor code inside the boot window.
// - Lock stays on until any processor or chip reset; no global erase is needed.
// - Global erase also clears engine program RAM, locked or not.
// - Emulator is inhibited for the first 32 boot cycles after reset.
// - Read-only boot-window status at bit 7 of register 0xb2.
// - After the window ends the emulator may be enabled and take control.
// - Lock bit at 0xb2 bit 6 clears on every processor reset.
// - Lock bit accepts only ones; writing zero leaves it unchanged.
// - While locked, every external program code read is blocked.
// - While locked, page erase of page zero is rejected from any source.
// - While locked, writes to page zero are suppressed from any source.
// - Emulator clock disable bit at 0x2005 bit 5 stops the emulator clock.
// - Chip reset clears all configuration bits including emulator clock disable.
`timescale 1ns/1ps
module program_code_security_lock (
    // Clock and resets
    input  wire logic        clock_i,
    input  wire logic        rst_i,           // Processor reset
    input  wire logic        chip_reset_n_i,  // Chip reset pin, active low
    // Special register port
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    output logic             sfr_hit_o,
    // Configuration RAM port
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [15:0] cfg_addr_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    output logic             cfg_hit_o,
    // Flash requests from processor
    input  wire logic        cpu_page_erase_i,
    input  wire logic        cpu_flash_write_i,
    input  wire logic [6:0]  cpu_page_i,
    // Flash requests from emulator
    input  wire logic        emu_page_erase_i,
    input  wire logic        emu_flash_write_i,
    input  wire logic        emu_code_read_i,
    input  wire logic        emu_other_op_i,
    input  wire logic        emu_global_erase_i,
    input  wire logic [6:0]  emu_page_i,
    // External program code read request
    input  wire logic        ext_code_read_i,
    // Global erase completion from the flash
    input  wire logic        global_erase_done_i,
    // Gated flash requests
    output logic             flash_page_erase_o,
    output logic             flash_write_o,
    output logic             flash_global_erase_o,
    output logic             engine_program_ram_clear_o,
    output logic             code_read_ok_o,
    // Emulator control
    output logic             emu_enable_o,
    output logic             emu_clock_en_o,
    output logic             emu_op_ok_o,
    // Lock status
    output logic             code_lock_bit_o,
    output logic             boot_window_o
);
    // ==================================================================
    // Reset synchroniser for chip reset pin (three stages)
    logic [2:0] chip_rst_sync;
    logic       chip_rst;
    logic       any_rst;

    always_ff @(posedge clock_i) begin
        chip_rst_sync <= {chip_rst_sync[1:0], ~chip_reset_n_i};
    end

    // Reset taken once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (chip_rst_sync[2] == chip_rst_sync[1]) begin
            chip_rst <= chip_rst_sync[2];
        end
    end

    assign any_rst = rst_i | chip_rst;

    // ==================================================================
    // Boot window
    logic in_window;

    boot_window_timer #(
        .WINDOW (code_lock_pkg::BOOT_WINDOW_CYCLES)
    ) u_boot_window (
        .clock_i     (clock_i),
        .rst_i       (any_rst),
        .in_window_o (in_window)
    );

    // ==================================================================
    // Register decode
    logic lock_sel;
    logic cfg_sel;

    assign lock_sel = (sfr_addr_i == code_lock_pkg::LOCK_CTRL_ADDR);
    assign cfg_sel  = (cfg_addr_i == code_lock_pkg::CONFIG_ONE_ADDR);

    // ==================================================================
    // Lock control register
    logic       code_lock_bit;
    logic [1:0] flash_ctl;       // Plain flash enable bits
    logic       erased_since;    // Global erase seen while locked

    // Lock bit: set only inside the window, cleared by reset
    always_ff @(posedge clock_i) begin
        if (any_rst && (!code_lock_bit || erased_since || chip_rst)) begin
            code_lock_bit <= 1'b0;
        end else if (any_rst) begin
            code_lock_bit <= 1'b0;
        end else if (sfr_wr_i && lock_sel && in_window &&
                     sfr_wdata_i[code_lock_pkg::LOCK_BIT]) begin
            code_lock_bit <= 1'b1;
        end
    end

    // Records a global erase while locked; the lock bit clears on any reset regardless
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            erased_since <= 1'b0;
        end else if (code_lock_bit && global_erase_done_i) begin
            erased_since <= 1'b1;
        end
    end

    // Ordinary flash control bits
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            flash_ctl <= code_lock_pkg::LOCK_CTRL_RESET[1:0];
        end else if (sfr_wr_i && lock_sel) begin
            flash_ctl <= {sfr_wdata_i[code_lock_pkg::FLASH_MEEN_BIT],
                          sfr_wdata_i[code_lock_pkg::FLASH_PWE_BIT]};
        end
    end

    // ==================================================================
    // Configuration register, cleared by chip reset only
    logic [7:0] chip_config_one;

    always_ff @(posedge clock_i) begin
        if (chip_rst) begin
            chip_config_one <= code_lock_pkg::CONFIG_ONE_RESET;
        end else if (cfg_wr_i && cfg_sel) begin
            chip_config_one <= cfg_wdata_i;
        end
    end

    logic emu_clock_off;
    assign emu_clock_off = chip_config_one[code_lock_pkg::EMU_CLK_OFF_BIT];

    // ==================================================================
    // Register read data
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i && lock_sel) begin
            sfr_rdata_o <= {in_window, code_lock_bit, 4'h0, flash_ctl};
        end else begin
            sfr_rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge clock_i) begin
        if (chip_rst) begin
            cfg_rdata_o <= 8'h00;
        end else if (cfg_rd_i && cfg_sel) begin
            cfg_rdata_o <= chip_config_one;
        end else begin
            cfg_rdata_o <= 8'h00;
        end
    end

    assign sfr_hit_o = lock_sel & (sfr_rd_i | sfr_wr_i);
    assign cfg_hit_o = cfg_sel & (cfg_rd_i | cfg_wr_i);

    // ==================================================================
    // Emulator gating
    logic emu_allowed;
    logic emu_any_op;

    // Emulator usable only after the window and with its clock running
    assign emu_allowed = !in_window && !emu_clock_off;
    assign emu_any_op  = emu_page_erase_i | emu_flash_write_i | emu_code_read_i |
                         emu_other_op_i;

    // ==================================================================
    // Flash request filtering
    logic cpu_erase_ok;
    logic cpu_write_ok;
    logic emu_erase_ok;
    logic emu_write_ok;
    logic emu_gerase_ok;

    // Page zero protected from page erase while locked
    assign cpu_erase_ok = cpu_page_erase_i &&
                          !(code_lock_bit && cpu_page_i == code_lock_pkg::BOOT_PAGE);
    // Page zero protected from writes while locked
    assign cpu_write_ok = cpu_flash_write_i &&
                          !(code_lock_bit && cpu_page_i == code_lock_pkg::BOOT_PAGE);
    // Emulator limited to global erase while locked
    assign emu_erase_ok = emu_page_erase_i && emu_allowed && !code_lock_bit;
    assign emu_write_ok = emu_flash_write_i && emu_allowed && !code_lock_bit;
    assign emu_gerase_ok = emu_global_erase_i && emu_allowed;

    // Registered flash strobes
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            flash_page_erase_o   <= 1'b0;
            flash_write_o        <= 1'b0;
            flash_global_erase_o <= 1'b0;
        end else begin
            flash_page_erase_o   <= cpu_erase_ok | emu_erase_ok;
            flash_write_o        <= cpu_write_ok | emu_write_ok;
            flash_global_erase_o <= emu_gerase_ok;
        end
    end

    // Program RAM cleared with every global erase
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            engine_program_ram_clear_o <= 1'b0;
        end else begin
            engine_program_ram_clear_o <= emu_gerase_ok;
        end
    end

    // Code reads and emulator operations
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            code_read_ok_o <= 1'b0;
            emu_op_ok_o    <= 1'b0;
        end else begin
            code_read_ok_o <= (ext_code_read_i | (emu_code_read_i && emu_allowed)) &&
                              !code_lock_bit;
            emu_op_ok_o    <= emu_allowed && (code_lock_bit ? emu_global_erase_i
                                              : (emu_any_op | emu_global_erase_i));
        end
    end

    // Emulator enable and clock
    always_ff @(posedge clock_i) begin
        if (any_rst) begin
            emu_enable_o   <= 1'b0;
            emu_clock_en_o <= 1'b0;
        end else begin
            emu_enable_o   <= !in_window;
            emu_clock_en_o <= !in_window && !emu_clock_off;
        end
    end

    assign code_lock_bit_o = code_lock_bit;
    assign boot_window_o   = in_window;
endmodule // program_code_security_lock

//--- tb/code_lock_asserts.sv
// Checker for the program code security lock
`timescale 1ns/1ps
module code_lock_asserts (
    // Clock and resets
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       chip_reset_n_i,
    // Special register port
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    // Flash requests and results
    input wire logic       cpu_page_erase_i,
    input wire logic       cpu_flash_write_i,
    input wire logic [6:0] cpu_page_i,
    input wire logic       emu_global_erase_i,
    input wire logic       flash_page_erase_o,
    input wire logic       flash_write_o,
    input wire logic       flash_global_erase_o,
    input wire logic       engine_program_ram_clear_o,
    // Emulator and lock state
    input wire logic       emu_enable_o,
    input wire logic       emu_op_ok_o,
    input wire logic       code_lock_bit_o,
    input wire logic       boot_window_o
);
    // ==================================================================
    // Helper state
    logic       set_req;
    logic [5:0] cnt;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Legal lock set seen on the previous edge
    always_ff @(posedge clock_i) begin
        set_req <= sfr_wr_i && sfr_addr_i == code_lock_pkg::LOCK_CTRL_ADDR && sfr_wdata_i[6]
                   && boot_window_o;
    end
    // Edges since processor reset release
    always_ff @(posedge clock_i) begin
        cnt <= rst_i ? 6'h00 : (cnt == 6'h3f ? cnt : cnt + 6'h01);
    end
    lock_set_a: assert property ($rose(code_lock_bit_o) |-> set_req)
        else $error("lock set without legal write");
    lock_hold_a: assert property (disable iff (rst_i || !chip_reset_n_i)
        code_lock_bit_o |=> code_lock_bit_o) else $error("lock dropped");
    window_len_a: assert property (cnt == 6'h20
        |-> !boot_window_o && $past(boot_window_o)) else $error("boot window length wrong");
    window_quiet_a: assert property (boot_window_o |-> !emu_enable_o ##1 !emu_op_ok_o)
        else $error("emulator active in window");
    locked_emu_a: assert property (code_lock_bit_o && !emu_global_erase_i
        |=> !emu_op_ok_o) else $error("emulator op while locked");
    page_zero_a: assert property (code_lock_bit_o && cpu_page_i == 7'h00
        && (cpu_page_erase_i || cpu_flash_write_i) |=> !flash_page_erase_o && !flash_write_o)
        else $error("page zero touched while locked");
    erase_ram_a: assert property (flash_global_erase_o |-> engine_program_ram_clear_o)
        else $error("program ram not cleared");
    status_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'hb2 |=> sfr_rdata_o[7:2]
        == {$past(boot_window_o), $past(code_lock_bit_o), 4'h0}) else $error("status read wrong");
endmodule // code_lock_asserts
bind program_code_security_lock code_lock_asserts i_code_lock_asserts (.clock_i, .rst_i,
    .chip_reset_n_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o,
    .cpu_page_erase_i, .cpu_flash_write_i, .cpu_page_i, .emu_global_erase_i,
    .flash_page_erase_o, .flash_write_o, .flash_global_erase_o, .engine_program_ram_clear_o,
    .emu_enable_o, .emu_op_ok_o, .code_lock_bit_o, .boot_window_o);

//--- tb/emu_model.sv
// Emulator model that turns a bench command into one request cycle
`timescale 1ns/1ps
module emu_model (
    // Clock and command
    input  wire logic       clock_i,
    input  wire logic       req_i,
    input  wire logic [2:0] cmd_i,
    input  wire logic [6:0] page_i,
    // Requests toward the lock
    output logic            page_erase_o,
    output logic            flash_write_o,
    output logic            code_read_o,
    output logic            other_op_o,
    output logic            global_erase_o,
    output logic [6:0]      page_o
);
    // One request cycle per command; page scrambled when idle
    always_ff @(posedge clock_i) begin
        page_erase_o   <= req_i && cmd_i == 3'h0;
        flash_write_o  <= req_i && cmd_i == 3'h1;
        code_read_o    <= req_i && cmd_i == 3'h2;
        other_op_o     <= req_i && cmd_i == 3'h3;
        global_erase_o <= req_i && cmd_i == 3'h4;
        page_o         <= req_i ? page_i : ~page_i;
    end
endmodule // emu_model

//--- tb/tb.sv
// Self-checking bench for the program code security lock
`timescale 1ns/1ps
module tb;
    // ==================================================================
    // Signals
    logic clock_i, rst_i, chip_reset_n_i, sfr_wr_i, sfr_rd_i, cfg_wr_i, cfg_rd_i, emu_req;
    logic cpu_page_erase_i, cpu_flash_write_i, ext_code_read_i, sfr_hit_o, cfg_hit_o;
    logic emu_page_erase_i, emu_flash_write_i, emu_code_read_i, emu_other_op_i;
    logic emu_global_erase_i, flash_page_erase_o, flash_write_o, flash_global_erase_o;
    logic engine_program_ram_clear_o, code_read_ok_o, emu_enable_o, emu_clock_en_o;
    logic emu_op_ok_o, code_lock_bit_o, boot_window_o;
    logic [7:0]  sfr_addr_i, sfr_wdata_i, cfg_wdata_i, sfr_rdata_o, cfg_rdata_o;
    logic [15:0] cfg_addr_i;
    logic [6:0]  cpu_page_i, emu_page, emu_page_i;
    logic [2:0]  emu_cmd;
    int fails, total_checks;
    // Request table: command, page, expected result flags
    logic [15:0] tbl [16] = '{16'h0000, 16'h2000, 16'h4000, 16'h6000, 16'h8006, 16'ha000,
        16'hc000, 16'ha0d0, 16'hc0c8, 16'he000, 16'h4020, 16'h6020, 16'h0010, 16'he001,
        16'hc008, 16'h8006};
    program_code_security_lock i_program_code_security_lock (.clock_i, .rst_i,
        .chip_reset_n_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o,
        .sfr_hit_o, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_hit_o,
        .cpu_page_erase_i, .cpu_flash_write_i, .cpu_page_i, .emu_page_erase_i,
        .emu_flash_write_i, .emu_code_read_i, .emu_other_op_i, .emu_global_erase_i,
        .emu_page_i, .ext_code_read_i, .global_erase_done_i(flash_global_erase_o),
        .flash_page_erase_o,
        .flash_write_o, .flash_global_erase_o, .engine_program_ram_clear_o, .code_read_ok_o,
        .emu_enable_o, .emu_clock_en_o, .emu_op_ok_o, .code_lock_bit_o, .boot_window_o);
    emu_model i_emu_model (.clock_i, .req_i(emu_req), .cmd_i(emu_cmd), .page_i(emu_page),
        .page_erase_o(emu_page_erase_i), .flash_write_o(emu_flash_write_i),
        .code_read_o(emu_code_read_i), .other_op_o(emu_other_op_i),
        .global_erase_o(emu_global_erase_i), .page_o(emu_page_i));
    // Clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // Comparison with report
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Register write on either port
    task automatic reg_wr(input logic c, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        {sfr_wr_i, cfg_wr_i, sfr_addr_i, cfg_addr_i} <= {!c, c, a[7:0], a};
        {sfr_wdata_i, cfg_wdata_i} <= {d, d};
        @(posedge clock_i);
        {sfr_wr_i, cfg_wr_i} <= 2'h0;
    endtask
    // Register read on either port
    task automatic reg_rd(input logic c, input logic [15:0] a, input logic [7:0] e, string n);
        @(posedge clock_i);
        {sfr_rd_i, cfg_rd_i, sfr_addr_i, cfg_addr_i} <= {!c, c, a[7:0], a};
        #1 chk("register hit", {7'h00, c ? a == 16'h2005 : a == 16'h00b2},
               {7'h00, c ? cfg_hit_o : sfr_hit_o});
        @(posedge clock_i);
        {sfr_rd_i, cfg_rd_i} <= 2'h0;
        #1 chk(n, e, c ? cfg_rdata_o : sfr_rdata_o);
    endtask
    // One request from a table entry, results gathered over four cycles
    task automatic act(input int i);
        logic [5:0] o;
        logic [2:0] op;
        o = 6'h00;
        op = tbl[i][15:13];
        @(posedge clock_i);
        {emu_req, emu_cmd, emu_page, cpu_page_i} <= {op < 3'h5, op, tbl[i][12:6], tbl[i][12:6]};
        {cpu_page_erase_i, cpu_flash_write_i, ext_code_read_i} <=
            {op == 3'h5, op == 3'h6, op == 3'h7};
        // Gather from the edge that takes a processor request onward
        repeat (4) begin
            @(posedge clock_i);
            {emu_req, cpu_page_erase_i, cpu_flash_write_i, ext_code_read_i} <= 4'h0;
            #1 o = o | {emu_op_ok_o, flash_page_erase_o, flash_write_o, flash_global_erase_o,
                        engine_program_ram_clear_o, code_read_ok_o};
        end
        o[5] = o[5] & (op == 3'h2 || op == 3'h3);
        o[0] = o[0] & (op == 3'h7);
        chk($sformatf("request %0d", i), {2'h0, tbl[i][5:0]}, {2'h0, o});
    endtask
    // Processor reset, optionally with the chip reset pin, 15 cycles
    task automatic do_rst(input logic chip);
        @(posedge clock_i);
        rst_i <= 1'b1;
        chip_reset_n_i <= !chip;
        repeat (5) @(posedge clock_i);
        chip_reset_n_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
    endtask
    // Watchdog
    initial begin
        #400000;
        fails++;
        close_out();
    end
    // Main sequence
    initial begin
        {sfr_wr_i, sfr_rd_i, cfg_wr_i, cfg_rd_i, emu_req, emu_cmd, emu_page} = '0;
        {cpu_page_erase_i, cpu_flash_write_i, ext_code_read_i, cpu_page_i} = '0;
        {sfr_addr_i, sfr_wdata_i, cfg_wdata_i, cfg_addr_i, fails, total_checks} = '0;
        rst_i = 1'b1;
        chip_reset_n_i = 1'b0;
        do_rst(1'b1);
        reg_rd(1'b0, 16'h00b2, 8'h80, "window status");
        chk("emu enable in window", 8'h00, {7'h00, emu_enable_o});
        act(2);
        reg_wr(1'b0, 16'h00b2, 8'h40);
        reg_wr(1'b0, 16'h00b2, 8'h00);
        reg_rd(1'b0, 16'h00b2, 8'hc0, "lock in window");
        repeat (30) @(posedge clock_i);
        reg_rd(1'b0, 16'h00b2, 8'h40, "lock after window");
        for (int i = 0; i < 10; i++) act(i);
        do_rst(1'b0);
        reg_rd(1'b0, 16'h00b2, 8'h80, "lock after reset");
        repeat (40) @(posedge clock_i);
        reg_wr(1'b0, 16'h00b2, 8'h40);
        reg_rd(1'b0, 16'h00b2, 8'h00, "late lock write");
        for (int i = 10; i < 16; i++) act(i);
        reg_wr(1'b1, 16'h2005, 8'h20);
        reg_rd(1'b1, 16'h2005, 8'h20, "config read");
        chk("emu clock", 8'h00, {7'h00, emu_clock_en_o});
        act(2);
        reg_rd(1'b1, 16'h2006, 8'h00, "unmapped read");
        do_rst(1'b0);
        reg_rd(1'b1, 16'h2005, 8'h20, "config kept");
        do_rst(1'b1);
        reg_rd(1'b1, 16'h2005, 8'h00, "config cleared");
        repeat (40) @(posedge clock_i);
        chk("emu enable late", 8'h03, {6'h00, emu_enable_o, emu_clock_en_o});
        close_out();
    end
endmodule // tb
